// [inc/fssh_pkg.sv]
// Shared types and constants for the framer side status and host port logic.
// Assumes one system clock; all pins from outside arrive asynchronously.
package fssh_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NPORT  = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NLINE  = 4;

  // ==========================================================================
  // Register map and reset values
  localparam logic [ADDR_W-1:0] ADDR_IO_MODE   = 7'h05;
  localparam logic [ADDR_W-1:0] ADDR_SW_STATUS = 7'h07;
  localparam logic [DATA_W-1:0] IO_MODE_RST    = 8'h00;
  localparam logic [DATA_W-1:0] SW_STATUS_RST  = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ  = 8'h00;

  // ==========================================================================
  // Field positions of the I/O mode register
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned SEL_MSB        = 1;
  localparam int unsigned BIT_SELECT_POL = 2;
  localparam int unsigned BIT_MARKER_POL = 4;
  localparam int unsigned BIT_HOLD_POL   = 7;

  // ==========================================================================
  // Status line select codes
  localparam logic [1:0] SEL_RX_HEALTH = 2'h0;
  localparam logic [1:0] SEL_TRAFFIC   = 2'h1;
  localparam logic [1:0] SEL_FAULTS    = 2'h2;
  localparam logic [1:0] SEL_SOFTWARE  = 2'h3;

  // ==========================================================================
  // Timing of the host clock against the system clock
  localparam int unsigned SYS_CLK_MHZ      = 200;
  localparam int unsigned HOST_CLK_MIN_MHZ = 8;
  localparam int unsigned HOST_CLK_MAX_MHZ = 50;
  localparam int unsigned HOST_MIN_HALF_NS = 1000 / (2 * HOST_CLK_MAX_MHZ);
  localparam int unsigned HOST_HALF_CYC    = (HOST_MIN_HALF_NS * SYS_CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    FSSH_ACC_IDLE,
    FSSH_ACC_READ,
    FSSH_ACC_WRITE
  } fssh_acc_t;

  typedef struct packed {
    logic [NPORT-1:0] header_mismatch;
    logic [NPORT-1:0] receive_overflow;
    logic [NPORT-1:0] header_check_corrected;
    logic [NPORT-1:0] idle_cell_seen;
    logic [NPORT-1:0] transmit_overflow;
    logic [NPORT-1:0] header_check_error_seen;
    logic [NPORT-1:0] cell_arrived;
    logic [NPORT-1:0] start_of_cell_fault;
    logic [NPORT-1:0] delineation_lost;
    logic [NPORT-1:0] cell_departed;
    logic [NPORT-1:0] parity_fault;
  } fssh_events_t;

  typedef struct packed {
    logic              clock;
    logic              style;
    logic              select_n;
    logic              dir_or_rd_n;
    logic              as_or_wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fssh_host_pins_t;

  typedef struct packed {
    logic [DATA_W-1:0]           io_mode;
    logic [DATA_W-1:0]           sw_status;
    fssh_acc_t                   acc;
    logic [DATA_W-1:0]           rdata;
    logic                        data_oe;
    logic                        irq_n;
    logic                        hclk_prev;
    logic [NPORT-1:0]            held;
    logic [NPORT-1:0]            marker;
    logic [NPORT-1:0]            select;
    logic [NLINE-1:0][NPORT-1:0] status;
  } fssh_state_t;

endpackage

// [src/fssh_sync.sv]
// Three-stage synchroniser for a vector of asynchronous pins.
// Assumes the pins are quiet for at least two system clocks around a change.
`timescale 1ns/1ps
module fssh_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] val_o
);

  // ==========================================================================
  // Stages
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] val_q;
  logic         init_q;

  // A bit changes only once the second and third stages agree.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      val_q  <= '0;
      init_q <= 1'b0;
    end else begin
      s1_q   <= pin_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      init_q <= 1'b1;
      for (int i = 0; i < W; i++) begin
        if (!init_q) begin
          val_q[i] <= rst_val_i[i];
        end else if (s2_q[i] == s3_q[i]) begin
          val_q[i] <= s3_q[i];
        end
      end
    end
  end

  // Idle values stand in for the pins until the stages have been loaded once.
  assign val_o = init_q ? val_q : rst_val_i;

endmodule

// [src/fssh_status_mux.sv]
// Selects what the four status lines of every port show.
// Assumes all inputs are on the system clock; the result is combinational.
`timescale 1ns/1ps
module fssh_status_mux (
  input  wire logic [1:0]                                    sel_i,
  input  wire logic [fssh_pkg::NPORT-1:0]                    held_i,
  input  wire fssh_pkg::fssh_events_t                        ev_i,
  input  wire logic [fssh_pkg::NLINE-1:0]                    sw_i,
  output logic      [fssh_pkg::NLINE-1:0][fssh_pkg::NPORT-1:0] lines_o
);

  // ==========================================================================
  // Selection
  always_comb begin
    unique case (sel_i)
      fssh_pkg::SEL_RX_HEALTH: begin
        lines_o[3] = held_i;
        lines_o[2] = ev_i.header_check_corrected;
        lines_o[1] = ev_i.header_check_error_seen;
        lines_o[0] = ev_i.delineation_lost;
      end
      fssh_pkg::SEL_TRAFFIC: begin
        lines_o[3] = ev_i.header_mismatch;
        lines_o[2] = ev_i.idle_cell_seen;
        lines_o[1] = ev_i.cell_arrived;
        lines_o[0] = ev_i.cell_departed;
      end
      fssh_pkg::SEL_FAULTS: begin
        lines_o[3] = ev_i.receive_overflow;
        lines_o[2] = ev_i.transmit_overflow;
        lines_o[1] = ev_i.start_of_cell_fault;
        lines_o[0] = ev_i.parity_fault;
      end
      fssh_pkg::SEL_SOFTWARE: begin
        for (int l = 0; l < fssh_pkg::NLINE; l++) begin
          lines_o[l] = {fssh_pkg::NPORT{sw_i[l]}};
        end
      end
    endcase
  end

endmodule

// [src/fssh_top.sv]
// Framer side pins and host port front end of an eight port cell PHY.
// Assumes the cell core supplies status events on clk_sys_i and that all
// framer and host pins are asynchronous to it.
`timescale 1ns/1ps
module fssh_top (
  input  wire logic                                          clk_sys_i,
  input  wire logic                                          rstn_i,
  input  wire logic [fssh_pkg::NPORT-1:0]                    line_rx_frame_marker_i,
  input  wire logic [fssh_pkg::NPORT-1:0]                    line_rx_hold_in_i,
  input  wire logic [fssh_pkg::NPORT-1:0]                    framed_mode_i,
  input  wire logic [fssh_pkg::NPORT-1:0]                    line_irq_n_i,
  input  wire logic [fssh_pkg::NPORT-1:0]                    irq_forward_en_i,
  input  wire logic [fssh_pkg::NPORT-1:0]                    framer_select_req_i,
  input  wire fssh_pkg::fssh_events_t                        events_i,
  input  wire logic                                          host_clock_i,
  input  wire logic                                          host_bus_style_select_i,
  input  wire logic                                          host_select_n_i,
  input  wire logic                                          host_write_not_read_i,
  input  wire logic                                          host_addr_strobe_n_i,
  input  wire logic [fssh_pkg::ADDR_W-1:0]                   host_addr_i,
  input  wire logic [fssh_pkg::DATA_W-1:0]                   host_data_i,
  output logic      [fssh_pkg::DATA_W-1:0]                   host_data_o,
  output logic                                               host_data_oe_o,
  output logic                                               host_irq_n_o,
  output logic      [fssh_pkg::NPORT-1:0]                    framer_select_out_o,
  output logic      [fssh_pkg::NLINE-1:0][fssh_pkg::NPORT-1:0] port_status_lines_o,
  output logic      [fssh_pkg::NPORT-1:0]                    rx_frame_marker_o,
  output logic      [fssh_pkg::NPORT-1:0]                    receiver_held_o
);

  // ==========================================================================
  // Functions
  function automatic logic [fssh_pkg::NPORT-1:0] fssh_active(
    input logic [fssh_pkg::NPORT-1:0] pin,
    input logic                       pol
  );
    fssh_active = ~(pin ^ {fssh_pkg::NPORT{pol}});
  endfunction

  function automatic logic [fssh_pkg::DATA_W-1:0] fssh_read(
    input logic [fssh_pkg::ADDR_W-1:0] addr,
    input fssh_pkg::fssh_state_t       st
  );
    if (addr == fssh_pkg::ADDR_IO_MODE) begin
      fssh_read = st.io_mode;
    end else if (addr == fssh_pkg::ADDR_SW_STATUS) begin
      fssh_read = st.sw_status;
    end else begin
      fssh_read = fssh_pkg::UNMAPPED_READ;
    end
  endfunction

  // ==========================================================================
  // Pin synchronisers
  fssh_pkg::fssh_host_pins_t host_raw;
  fssh_pkg::fssh_host_pins_t host_s;
  fssh_pkg::fssh_host_pins_t host_rst;
  logic [fssh_pkg::NPORT-1:0] marker_s;
  logic [fssh_pkg::NPORT-1:0] hold_s;
  logic [fssh_pkg::NPORT-1:0] irq_s;
  logic [3*fssh_pkg::NPORT-1:0] line_s;

  always_comb begin
    host_raw.clock       = host_clock_i;
    host_raw.style       = host_bus_style_select_i;
    host_raw.select_n    = host_select_n_i;
    host_raw.dir_or_rd_n = host_write_not_read_i;
    host_raw.as_or_wr_n  = host_addr_strobe_n_i;
    host_raw.addr        = host_addr_i;
    host_raw.data        = host_data_i;
    host_rst             = '0;
    host_rst.select_n    = 1'b1;
    host_rst.dir_or_rd_n = 1'b1;
    host_rst.as_or_wr_n  = 1'b1;
  end

  fssh_sync #(
    .W ($bits(fssh_pkg::fssh_host_pins_t))
  ) u_host_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .pin_i     (host_raw),
    .rst_val_i (host_rst),
    .val_o     (host_s)
  );

  fssh_sync #(
    .W (3 * fssh_pkg::NPORT)
  ) u_line_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .pin_i     ({line_rx_frame_marker_i, line_rx_hold_in_i, line_irq_n_i}),
    .rst_val_i ({3*fssh_pkg::NPORT{1'b1}}),
    .val_o     (line_s)
  );

  assign marker_s = line_s[3*fssh_pkg::NPORT-1:2*fssh_pkg::NPORT];
  assign hold_s   = line_s[2*fssh_pkg::NPORT-1:fssh_pkg::NPORT];
  assign irq_s    = line_s[fssh_pkg::NPORT-1:0];

  // ==========================================================================
  // State and status selection
  fssh_pkg::fssh_state_t q;
  fssh_pkg::fssh_state_t d;
  logic [fssh_pkg::NLINE-1:0][fssh_pkg::NPORT-1:0] mux_lines;
  logic [fssh_pkg::NPORT-1:0] held_now;
  logic                       hclk_rise;
  logic                       rd_req;
  logic                       wr_req;
  logic [fssh_pkg::NPORT-1:0] svc_req;

  assign held_now  = fssh_active(hold_s, q.io_mode[fssh_pkg::BIT_HOLD_POL]);
  assign hclk_rise = host_s.clock & ~q.hclk_prev;
  assign svc_req   = ~irq_s;

  fssh_status_mux u_status_mux (
    .sel_i   (q.io_mode[fssh_pkg::SEL_MSB:fssh_pkg::SEL_LSB]),
    .held_i  (q.held),
    .ev_i    (events_i),
    .sw_i    (q.sw_status[fssh_pkg::NLINE-1:0]),
    .lines_o (mux_lines)
  );

  // ==========================================================================
  // Host access decode
  always_comb begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    if (!host_s.select_n) begin
      if (host_s.style) begin
        rd_req = !host_s.as_or_wr_n && !host_s.dir_or_rd_n;
        wr_req = !host_s.as_or_wr_n && host_s.dir_or_rd_n;
      end else begin
        rd_req = !host_s.dir_or_rd_n && host_s.as_or_wr_n;
        wr_req = !host_s.as_or_wr_n && host_s.dir_or_rd_n;
      end
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    d           = q;
    d.hclk_prev = host_s.clock;
    d.held      = held_now;
    d.marker    = fssh_active(marker_s, q.io_mode[fssh_pkg::BIT_MARKER_POL])
                  & framed_mode_i & ~held_now;
    d.select    = fssh_active(framer_select_req_i,
                              q.io_mode[fssh_pkg::BIT_SELECT_POL]);
    d.status    = mux_lines;
    if (hclk_rise) begin
      d.irq_n = ~|(svc_req & irq_forward_en_i);
      if (wr_req) begin
        d.acc     = fssh_pkg::FSSH_ACC_WRITE;
        d.data_oe = 1'b0;
        if (host_s.addr == fssh_pkg::ADDR_IO_MODE) begin
          d.io_mode = host_s.data;
        end else if (host_s.addr == fssh_pkg::ADDR_SW_STATUS) begin
          d.sw_status = host_s.data;
        end
      end else if (rd_req) begin
        d.acc     = fssh_pkg::FSSH_ACC_READ;
        d.rdata   = fssh_read(host_s.addr, q);
        d.data_oe = 1'b1;
      end else begin
        d.acc     = fssh_pkg::FSSH_ACC_IDLE;
        d.data_oe = 1'b0;
      end
    end
    if (host_s.select_n) begin
      d.acc     = fssh_pkg::FSSH_ACC_IDLE;
      d.data_oe = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q           <= '0;
      q.io_mode   <= fssh_pkg::IO_MODE_RST;
      q.sw_status <= fssh_pkg::SW_STATUS_RST;
      q.acc       <= fssh_pkg::FSSH_ACC_IDLE;
      q.irq_n     <= 1'b1;
      q.hclk_prev <= 1'b0;
      q.select    <= '1;
    end else begin
      q <= d;
    end
  end

  assign host_data_o         = q.rdata;
  assign host_data_oe_o      = q.data_oe;
  assign host_irq_n_o        = q.irq_n;
  assign framer_select_out_o = q.select;
  assign port_status_lines_o = q.status;
  assign rx_frame_marker_o   = q.marker;
  assign receiver_held_o     = q.held;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_sync_write;
    hclk_rise && !host_s.select_n && host_s.style && !host_s.as_or_wr_n
      && host_s.dir_or_rd_n && host_s.addr == fssh_pkg::ADDR_IO_MODE;
  endsequence

  sequence s_async_write;
    hclk_rise && !host_s.select_n && !host_s.style && !host_s.as_or_wr_n
      && host_s.dir_or_rd_n && host_s.addr == fssh_pkg::ADDR_SW_STATUS;
  endsequence

  sequence s_deselected_edge;
    hclk_rise && host_s.select_n;
  endsequence

  a_marker_gating: assert property (
    ##1 (rx_frame_marker_o & ~$past(framed_mode_i)) == '0)
    else $error("frame marker passed on a port in general purpose mode");

  a_hold_polarity: assert property (
    ##1 receiver_held_o == ~($past(hold_s) ^ {fssh_pkg::NPORT{$past(q.io_mode[7])}}))
    else $error("receiver hold does not follow pin and polarity");

  a_select_level: assert property (
    q.io_mode[fssh_pkg::BIT_SELECT_POL] && $stable(framer_select_req_i)
      |=> framer_select_out_o == framer_select_req_i)
    else $error("framer select not active high when polarity bit is set");

  a_irq_forward: assert property (
    hclk_rise && (svc_req & irq_forward_en_i) != '0 |=> !host_irq_n_o)
    else $error("enabled framer interrupt not forwarded");

  a_irq_on_edge: assert property (
    !hclk_rise |=> $stable(host_irq_n_o))
    else $error("host interrupt changed without a host clock rise");

  a_line3_soft: assert property (
    q.io_mode[1:0] == fssh_pkg::SEL_SOFTWARE && $stable(q.io_mode)
      |=> port_status_lines_o[3] == {fssh_pkg::NPORT{$past(q.sw_status[3])}})
    else $error("status line 3 does not show software bit 3");

  a_line2_idle: assert property (
    q.io_mode[1:0] == fssh_pkg::SEL_TRAFFIC && $stable(q.io_mode)
      |=> port_status_lines_o[2] == $past(events_i.idle_cell_seen))
    else $error("status line 2 does not show idle cells");

  a_line1_fault: assert property (
    q.io_mode[1:0] == fssh_pkg::SEL_FAULTS && $stable(q.io_mode)
      |=> port_status_lines_o[1] == $past(events_i.start_of_cell_fault))
    else $error("status line 1 does not show start faults");

  a_line0_loss: assert property (
    q.io_mode[1:0] == fssh_pkg::SEL_RX_HEALTH && $stable(q.io_mode)
      |=> port_status_lines_o[0] == $past(events_i.delineation_lost))
    else $error("status line 0 does not show delineation loss");

  a_sync_write: assert property (
    s_sync_write |=> q.io_mode == $past(host_s.data) ##1 $stable(q.io_mode))
    else $error("synchronous write did not reach the mode register");

  a_async_write: assert property (
    s_async_write |=> q.sw_status == $past(host_s.data))
    else $error("asynchronous write did not reach the status register");

  a_deselect_ignore: assert property (
    s_deselected_edge |=> $stable(q.io_mode) && $stable(q.sw_status) && !host_data_oe_o)
    else $error("deselected device answered the host");

  a_read_drive: assert property (
    $rose(host_data_oe_o)
      |-> $past(hclk_rise) && $past(rd_req) && q.acc == fssh_pkg::FSSH_ACC_READ)
    else $error("data pins driven without a read");

endmodule

// [tb/fssh_framer_model.sv]
// Behavioural model of the eight line framers at the interrupt pins.
// Assumes the bench raises a per-port service request vector.
`timescale 1ns/1ps
module fssh_framer_model (
  input  wire logic [7:0] irq_req_i,
  output logic      [7:0] line_irq_n_o
);
  // ==========================================================================
  // Interrupt pins
  // Lines rest high as the pull-ups leave them; a request pulls its line low.
  assign line_irq_n_o = ~irq_req_i;
endmodule

// [tb/fssh_top_tb.sv]
// Self-checking bench for the framer side and host port front end.
// Assumes the design package is compiled first and a 200 MHz system clock.
`timescale 1ns/1ps
module fssh_top_tb;
  // ==========================================================================
  // Signals
  logic                   clk_sys_i = 1'b0;
  logic                   rstn_i    = 1'b0;
  logic                   hclk      = 1'b0;
  logic                   style     = 1'b1;
  logic                   sel_n     = 1'b0;
  logic                   p1        = 1'b0;
  logic                   p2        = 1'b1;
  logic [7:0]             mrk       = 8'hff;
  logic [7:0]             hold      = 8'hff;
  logic [7:0]             framed    = 8'hff;
  logic [7:0]             en        = 8'h00;
  logic [7:0]             sreq      = 8'h00;
  logic [7:0]             ireq      = 8'h00;
  logic [7:0]             din       = 8'h00;
  logic [6:0]             addr      = 7'h00;
  fssh_pkg::fssh_events_t ev        = '0;
  logic [7:0]             dout, irqv, fsel, mko, hld, rd_q;
  logic                   oe, irq_n;
  logic [3:0][7:0]        st;
  int                     err_total = 0;
  int                     compares  = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  fssh_framer_model u_frm (.irq_req_i(ireq), .line_irq_n_o(irqv));

  fssh_top uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .line_rx_frame_marker_i(mrk),
    .line_rx_hold_in_i(hold), .framed_mode_i(framed), .line_irq_n_i(irqv),
    .irq_forward_en_i(en), .framer_select_req_i(sreq), .events_i(ev), .host_clock_i(hclk),
    .host_bus_style_select_i(style), .host_select_n_i(sel_n), .host_write_not_read_i(p1),
    .host_addr_strobe_n_i(p2), .host_addr_i(addr), .host_data_i(din), .host_data_o(dout),
    .host_data_oe_o(oe), .host_irq_n_o(irq_n), .framer_select_out_o(fsel),
    .port_status_lines_o(st), .rx_frame_marker_o(mko), .receiver_held_o(hld));

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    compares++;
    if (seen !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // One host clock period of 105 ns with all pins held over the whole period.
  task automatic hcyc(input logic s, input logic cs, input logic a1, input logic a2,
                      input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    style <= s;
    sel_n <= cs;
    p1    <= a1;
    p2    <= a2;
    addr  <= a;
    din   <= d;
    cyc(6);
    hclk  <= 1'b1;
    cyc(10);
    rd_q  = dout;
    hclk  <= 1'b0;
    cyc(4);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    hcyc(1'b1, 1'b0, 1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [6:0] a);
    hcyc(1'b1, 1'b0, 1'b0, 1'b0, a, 8'h00);
  endtask

  function automatic logic [31:0] expl(input logic [1:0] s, input logic [7:0] sw);
    case (s)
      2'h0: expl = {8'h00, ev.header_check_corrected, ev.header_check_error_seen,
                    ev.delineation_lost};
      2'h1: expl = {ev.header_mismatch, ev.idle_cell_seen, ev.cell_arrived, ev.cell_departed};
      2'h2: expl = {ev.receive_overflow, ev.transmit_overflow, ev.start_of_cell_fault,
                    ev.parity_fault};
      default: expl = {{8{sw[3]}}, {8{sw[2]}}, {8{sw[1]}}, {8{sw[0]}}};
    endcase
  endfunction

  task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    cyc(8);
    rstn_i <= 1'b1;
    cyc(8);
    rd(7'h05);
    chk("io_mode reset", rd_q, 8'h00);
    chk("read enable", oe, 1'b1);
    rd(7'h07);
    chk("sw_status reset", rd_q, 8'h00);
    chk("selects reset", fsel, 8'hff);
    chk("lines reset", st, 32'h0);
    chk("irq reset", irq_n, 1'b1);
    $display("test reset done");
    hcyc(1'b0, 1'b0, 1'b1, 1'b0, 7'h07, 8'ha5);
    hcyc(1'b0, 1'b0, 1'b0, 1'b0, 7'h07, 8'h00);
    hcyc(1'b0, 1'b0, 1'b0, 1'b1, 7'h07, 8'h00);
    chk("async read", rd_q, 8'ha5);
    rd(7'h10);
    chk("unmapped read", rd_q, 8'h00);
    hcyc(1'b1, 1'b1, 1'b1, 1'b0, 7'h07, 8'h00);
    chk("deselected enable", oe, 1'b0);
    rd(7'h07);
    chk("deselected write", rd_q, 8'ha5);
    $display("test access done");
    ev <= {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h03, 8'h0c, 8'h30};
    for (int s = 0; s < 4; s++) begin
      wr(7'h05, 8'(s));
      rd(7'h05);
      chk("io_mode", rd_q, 8'(s));
      chk("status lines", st, expl(2'(s), 8'ha5));
    end
    $display("test status done");
    sreq <= 8'h05;
    wr(7'h05, 8'h00);
    chk("select low", fsel, 8'hfa);
    wr(7'h05, 8'h04);
    chk("select high", fsel, 8'h05);
    wr(7'h05, 8'h00);
    hold <= 8'hfb;
    mrk  <= 8'hfe;
    cyc(10);
    chk("held low", hld, 8'h04);
    chk("held line", st[3], 8'h04);
    chk("marker low", mko, 8'h01);
    framed <= 8'h00;
    cyc(10);
    chk("marker ignored", mko, 8'h00);
    framed <= 8'hff;
    wr(7'h05, 8'h10);
    chk("marker high", mko, 8'hfa);
    wr(7'h05, 8'h80);
    chk("held high", hld, 8'hfb);
    $display("test pins done");
    en   <= 8'h08;
    ireq <= 8'h0c;
    cyc(20);
    chk("irq waits", irq_n, 1'b1);
    rd(7'h07);
    chk("irq on", irq_n, 1'b0);
    ireq <= 8'h04;
    hcyc(1'b1, 1'b1, 1'b0, 1'b0, 7'h07, 8'h00);
    chk("irq deselected", irq_n, 1'b1);
    $display("test irq done");
    rstn_i <= 1'b0;
    cyc(2);
    rstn_i <= 1'b1;
    cyc(8);
    rd(7'h05);
    chk("io_mode rerun", rd_q, 8'h00);
    $display("test reset again done");
    results;
  end

  initial begin
    cyc(20000);
    err_total++;
    results;
  end
endmodule
